// ### src/phrs_status.sv
// Peak hold, region and temperature-ready status registers behind an APB slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Region field reports active calibration set 0-4
// - Region reads 1111 when disabled and after reset
// - Current peak magnitude is sample shifted right five
// - Current peak phase flags: bit0 A, 1 B, 2 C
// - Peak select bits 4:2 choose monitored channels
// - Voltage peak magnitude is sample shifted right five
// - Voltage peak phase flags: bit0 A, 1 B, 2 C
// - Temperature-ready bit 25 set on new result
module phrs_status (
   input wire logic clock, // 50 MHz clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic clkEn, // Clock enable, freezes all state while low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high for write
   input wire logic [12:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   input wire logic [3:0] regionIn, // Set index chosen by compensation datapath
   input wire logic [2:0] sampleValid, // Per phase sample strobe, A B C
   input wire logic [95:0] currentSample, // Current samples, A low, signed
   input wire logic [95:0] voltageSample, // Voltage samples, A low, signed
   input wire logic peakClear, // Restart peak capture
   input wire logic tempDone, // One-cycle pulse, new temperature result
   output logic irq // Level interrupt
);

   logic [3:0] regionR;
   logic mtenR;
   logic [2:0] peakSelR;
   logic [23:0] iMagR, vMagR;
   logic [2:0] iPhR, vPhR;
   logic tempRdyR;
   logic [31:0] maskR;
   logic [31:0] rdR;
   logic errR;

   wire access = psel && penable && clkEn;
   wire wrAcc = access && pwrite;
   wire rdAcc = access && !pwrite;
   wire hitRegion = paddr == phrs_pkg::REGION_BYTE;
   wire hitIpeak = paddr == phrs_pkg::CURRENT_PEAK_HOLD_BYTE;
   wire hitVpeak = paddr == phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE;
   wire hitStat = paddr == phrs_pkg::STAT0_BYTE;
   wire hitCfg0 = paddr == phrs_pkg::CFG0_BYTE;
   wire hitCfg3 = paddr == phrs_pkg::CFG3_BYTE;
   wire hitMask = paddr == phrs_pkg::IRQMASK_BYTE;
   wire hitAny = hitRegion | hitIpeak | hitVpeak | hitStat | hitCfg0 | hitCfg3 | hitMask;

   // Region: out-of-range indices are not a valid set, so they hold the last one
   wire regionOk = regionIn <= phrs_pkg::REGION_MAX;
   wire [3:0] regionNxt = !mtenR ? phrs_pkg::REGION_DISABLED : (regionOk ? regionIn : regionR);

   // Per-phase magnitude, shifted and compared against the held peak
   logic [23:0] iMag [3];
   logic [23:0] vMag [3];
   logic [2:0] iCand, vCand;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gPh
         wire [31:0] ci = currentSample[g*32 +: 32];
         wire [31:0] cv = voltageSample[g*32 +: 32];
         wire [31:0] ai = ci[31] ? 32'(-ci) : ci;
         wire [31:0] av = cv[31] ? 32'(-cv) : cv;
         assign iMag[g] = ai[phrs_pkg::PEAK_SHIFT +: 24];
         assign vMag[g] = av[phrs_pkg::PEAK_SHIFT +: 24];
         assign iCand[g] = sampleValid[g] && peakSelR[g] && iMag[g] > iMagR;
         assign vCand[g] = sampleValid[g] && peakSelR[g] && vMag[g] > vMagR;
      end
   endgenerate

   // Pick the largest candidate; ties keep the lowest phase so one flag is set
   logic [23:0] iBest, vBest;
   logic [2:0] iBestPh, vBestPh;
   always_comb begin
      iBest = iMagR;
      vBest = vMagR;
      iBestPh = 3'h0;
      vBestPh = 3'h0;
      for (int k = 0; k < 3; k++) begin
         if (iCand[k] && iMag[k] > iBest) begin
            iBest = iMag[k];
            iBestPh = 3'(1 << k);
         end
         if (vCand[k] && vMag[k] > vBest) begin
            vBest = vMag[k];
            vBestPh = 3'(1 << k);
         end
      end
   end
   wire iUpd = |iBestPh;
   wire vUpd = |vBestPh;

   // Set wins over the write-one clear
   wire tempClr = wrAcc && hitStat && pwdata[phrs_pkg::TEMP_RDY_BIT];
   wire tempNxt = tempDone | (tempRdyR & ~tempClr);

   wire [31:0] regionWord = {28'h0000000, regionR};
   wire [31:0] ipeakWord = {5'h00, iPhR, iMagR};
   wire [31:0] vpeakWord = {5'h00, vPhR, vMagR};
   wire [31:0] statWord = 32'(tempRdyR) << phrs_pkg::TEMP_RDY_BIT;
   wire [31:0] cfg0Word = 32'(mtenR) << phrs_pkg::MULTIPOINT_COMP_ENABLE_BIT;
   wire [31:0] cfg3Word = 32'(peakSelR) << phrs_pkg::PEAK_CHANNEL_SELECT_LSB;
   wire [31:0] rdMux = hitRegion ? regionWord : hitIpeak ? ipeakWord : hitVpeak ? vpeakWord :
                       hitStat ? statWord : hitCfg0 ? cfg0Word : hitCfg3 ? cfg3Word :
                       hitMask ? maskR : 32'h00000000;

   assign pready = 1'b1;
   assign prdata = rdR;
   assign pslverr = errR;
   assign irq = |(statWord & maskR);

   // Read data and error are registered in setup so they stand in the access cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         rdR <= 32'h00000000;
         errR <= 1'b0;
      end else if (clkEn) begin
         rdR <= (psel && !pwrite) ? rdMux : 32'h00000000;
         errR <= psel && !penable && !hitAny;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         regionR <= phrs_pkg::REGION_RESET;
         mtenR <= 1'b0;
         peakSelR <= phrs_pkg::PEAK_CHANNEL_SELECT_RESET;
         maskR <= 32'h00000000;
         tempRdyR <= 1'b0;
      end else if (clkEn) begin
         regionR <= regionNxt;
         tempRdyR <= tempNxt;
         if (wrAcc && hitCfg0) begin
            mtenR <= pwdata[phrs_pkg::MULTIPOINT_COMP_ENABLE_BIT];
         end
         if (wrAcc && hitCfg3) begin
            peakSelR <= pwdata[phrs_pkg::PEAK_CHANNEL_SELECT_LSB +: 3];
         end
         if (wrAcc && hitMask) begin
            maskR <= pwdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         iMagR <= phrs_pkg::PEAK_RESET;
         vMagR <= phrs_pkg::PEAK_RESET;
         iPhR <= 3'h0;
         vPhR <= 3'h0;
      end else if (clkEn) begin
         if (peakClear) begin
            iMagR <= phrs_pkg::PEAK_RESET;
            vMagR <= phrs_pkg::PEAK_RESET;
            iPhR <= 3'h0;
            vPhR <= 3'h0;
         end else begin
            if (iUpd) begin
               iMagR <= iBest;
               iPhR <= iBestPh;
            end
            if (vUpd) begin
               vMagR <= vBest;
               vPhR <= vBestPh;
            end
         end
      end
   end

   chk_region_disabled: assert property (@(posedge clock) disable iff (srst)
      clkEn && !mtenR |=> regionR == phrs_pkg::REGION_DISABLED)
      else $error("region not 1111 while disabled");
   chk_region_follows: assert property (@(posedge clock) disable iff (srst)
      clkEn && mtenR && regionIn <= phrs_pkg::REGION_MAX |=> regionR == $past(regionIn))
      else $error("region does not follow set index");
   chk_region_range: assert property (@(posedge clock) disable iff (srst)
      regionR <= phrs_pkg::REGION_MAX || regionR == phrs_pkg::REGION_DISABLED)
      else $error("region holds illegal code");
   chk_current_peak_hold_grow: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear |=> iMagR >= $past(iMagR))
      else $error("current peak shrank");
   chk_iphase_onehot: assert property (@(posedge clock) disable iff (srst)
      $changed(iMagR) && iMagR != 24'h000000 |-> $onehot(iPhR))
      else $error("current phase flags not single");
   chk_peak_select: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear && $changed(iPhR) ##0 1 |-> 1'b1 && (((iPhR & ~$past(peakSelR)) == 3'h0) || iPhR == 3'h0))
      else $error("unselected phase captured");
   chk_voltage_peak_hold_grow: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear |=> vMagR >= $past(vMagR))
      else $error("voltage peak shrank");
   chk_vphase_onehot: assert property (@(posedge clock) disable iff (srst)
      $changed(vMagR) && vMagR != 24'h000000 |-> $onehot(vPhR))
      else $error("voltage phase flags not single");
   chk_temp_set: assert property (@(posedge clock) disable iff (srst)
      clkEn && tempDone |=> tempRdyR)
      else $error("temperature ready not set");
   chk_temp_sticky: assert property (@(posedge clock) disable iff (srst)
      tempRdyR && !(wrAcc && hitStat && pwdata[phrs_pkg::TEMP_RDY_BIT]) |=> tempRdyR)
      else $error("temperature ready lost without clear");

   // Checks on clear paths, masking, region hold and peak growth that the scenarios reach only briefly
   chk_temp_clear: assert property (@(posedge clock) disable iff (srst)
      clkEn && tempRdyR && tempClr && !tempDone |=> !tempRdyR)
      else $error("temperature ready not cleared by write one");
   chk_temp_quiet: assert property (@(posedge clock) disable iff (srst)
      clkEn && !tempRdyR && !tempDone |=> !tempRdyR)
      else $error("temperature ready set without a result");
   chk_irq_level: assert property (@(posedge clock) disable iff (srst)
      irq == (tempRdyR && maskR[phrs_pkg::TEMP_RDY_BIT]))
      else $error("interrupt level wrong");
   chk_region_hold: assert property (@(posedge clock) disable iff (srst)
      clkEn && mtenR && regionIn > phrs_pkg::REGION_MAX |=> regionR == $past(regionR))
      else $error("region took an invalid index");
   chk_iphase_select: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear && iUpd |=> (iPhR & ~$past(peakSelR)) == 3'h0)
      else $error("unselected current phase captured");
   chk_vphase_select: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear && vUpd |=> (vPhR & ~$past(peakSelR)) == 3'h0)
      else $error("unselected voltage phase captured");
   chk_current_peak_hold_rise: assert property (@(posedge clock) disable iff (srst)
      clkEn && !peakClear && iUpd |=> iMagR > $past(iMagR))
      else $error("current peak update did not grow");
   chk_current_peak_hold_clear: assert property (@(posedge clock) disable iff (srst)
      clkEn && peakClear |=> iMagR == phrs_pkg::PEAK_RESET && iPhR == 3'h0)
      else $error("current peak not cleared");
   chk_voltage_peak_hold_clear: assert property (@(posedge clock) disable iff (srst)
      clkEn && peakClear |=> vMagR == phrs_pkg::PEAK_RESET && vPhR == 3'h0)
      else $error("voltage peak not cleared");

endmodule : phrs_status

`default_nettype wire

// ### src/phrs_pkg.sv
// Package: register map, field layout and reset values of the peak and region status group
package phrs_pkg;
   // Printed offsets are word indices; byte address is four times the index
   localparam logic [11:0] REGION_IDX = 12'h25d;
   localparam logic [11:0] CURRENT_PEAK_HOLD_IDX = 12'h400;
   localparam logic [11:0] VOLTAGE_PEAK_HOLD_IDX = 12'h401;
   localparam logic [11:0] STAT0_IDX = 12'h402;
   localparam logic [11:0] CFG0_IDX = 12'h403;
   localparam logic [11:0] CFG3_IDX = 12'h404;
   localparam logic [11:0] IRQMASK_IDX = 12'h405;
   // Indices reach 0x405, so byte addresses need thirteen bits
   localparam logic [12:0] REGION_BYTE = {REGION_IDX[10:0], 2'b00};
   localparam logic [12:0] CURRENT_PEAK_HOLD_BYTE = {CURRENT_PEAK_HOLD_IDX[10:0], 2'b00};
   localparam logic [12:0] VOLTAGE_PEAK_HOLD_BYTE = {VOLTAGE_PEAK_HOLD_IDX[10:0], 2'b00};
   localparam logic [12:0] STAT0_BYTE = {STAT0_IDX[10:0], 2'b00};
   localparam logic [12:0] CFG0_BYTE = {CFG0_IDX[10:0], 2'b00};
   localparam logic [12:0] CFG3_BYTE = {CFG3_IDX[10:0], 2'b00};
   localparam logic [12:0] IRQMASK_BYTE = {IRQMASK_IDX[10:0], 2'b00};
   localparam logic [3:0] REGION_RESET = 4'hf;
   localparam logic [3:0] REGION_DISABLED = 4'hf;
   localparam logic [3:0] REGION_MAX = 4'h4;
   localparam int MULTIPOINT_COMP_ENABLE_BIT = 0;
   localparam int PEAK_CHANNEL_SELECT_LSB = 2;
   localparam int PHASE_LSB = 24;
   localparam int TEMP_RDY_BIT = 25;
   localparam int PEAK_SHIFT = 5;
   localparam logic [2:0] PEAK_CHANNEL_SELECT_RESET = 3'h7;
   localparam logic [23:0] PEAK_RESET = 24'h000000;
endpackage : phrs_pkg

// ### verif/phrs_tb.sv
// Self-checking bench for the peak hold, region and temperature status group
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [12:0] paddr = 13'h0000;
   logic clkEn = 1'b1;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] regionIn = 4'h0;
   logic [2:0] sampleValid = 3'h0;
   logic [95:0] currentSample = 96'h0;
   logic [95:0] voltageSample = 96'h0;
   logic peakClear = 1'b0;
   logic tempDone = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic [31:0] q;
   logic e;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   phrs_status dut (.clock(clock), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .regionIn(regionIn),
      .sampleValid(sampleValid), .currentSample(currentSample), .voltageSample(voltageSample),
      .peakClear(peakClear), .tempDone(tempDone), .irq(irq));
   initial forever #10 clock = ~clock;
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   always @(posedge clock) begin
      cycles <= cycles + 1;
      // Generous ceiling, the whole run needs well under a thousand cycles
      if (cycles == 5000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // Entered just after a rising edge; read data and error are taken at the pready edge
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic rd(input logic [12:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(q, exp, what);
   endtask : rd
   task automatic smp(input logic [2:0] v, input logic [95:0] c, input logic [95:0] u);
      sampleValid <= v;
      currentSample <= c;
      voltageSample <= u;
      @(posedge clock);
      sampleValid <= 3'h0;
      @(posedge clock);
   endtask : smp
   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(phrs_pkg::REGION_BYTE, 32'hf, "region reset");
      rd(phrs_pkg::CURRENT_PEAK_HOLD_BYTE, 32'h0, "current_peak_hold reset");
      rd(phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE, 32'h0, "voltage_peak_hold reset");
      rd(phrs_pkg::STAT0_BYTE, 32'h0, "status reset");
      apb(1'b0, 13'h00f0, 32'h0);
      check({31'h0, e}, 32'h1, "unmapped error");
      check(q, 32'h0, "unmapped data");
      $display("test reset done");
      apb(1'b1, phrs_pkg::CFG0_BYTE, 32'h1);
      for (int i = 0; i < 5; i++) begin
         regionIn <= 4'(i);
         // The region register takes the index one edge later
         @(posedge clock);
         rd(phrs_pkg::REGION_BYTE, 32'(i), "region set");
      end
      regionIn <= 4'h9;
      @(posedge clock);
      rd(phrs_pkg::REGION_BYTE, 32'h4, "region hold");
      apb(1'b1, phrs_pkg::CFG0_BYTE, 32'h0);
      rd(phrs_pkg::REGION_BYTE, 32'hf, "region off");
      $display("test region done");
      // Negative current on B and positive voltage on C both fold to magnitude
      smp(3'b110, {32'h0, 32'hfffff000, 32'h0}, {32'h00002000, 32'h0, 32'h0});
      rd(phrs_pkg::CURRENT_PEAK_HOLD_BYTE, 32'h02000080, "current_peak_hold B");
      rd(phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE, 32'h04000100, "voltage_peak_hold C");
      apb(1'b1, phrs_pkg::CFG3_BYTE, 32'h4);
      smp(3'b110, {32'h0, 32'h00100000, 32'h0}, {32'h00100000, 32'h0, 32'h0});
      rd(phrs_pkg::CURRENT_PEAK_HOLD_BYTE, 32'h02000080, "current_peak_hold masked");
      rd(phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE, 32'h04000100, "voltage_peak_hold masked");
      smp(3'b111, {64'h0, 32'h00100000}, {64'h0, 32'h00200000});
      rd(phrs_pkg::CURRENT_PEAK_HOLD_BYTE, 32'h01008000, "current_peak_hold A");
      rd(phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE, 32'h01010000, "voltage_peak_hold A");
      peakClear <= 1'b1;
      @(posedge clock);
      peakClear <= 1'b0;
      rd(phrs_pkg::CURRENT_PEAK_HOLD_BYTE, 32'h0, "current_peak_hold cleared");
      rd(phrs_pkg::VOLTAGE_PEAK_HOLD_BYTE, 32'h0, "voltage_peak_hold cleared");
      $display("test peak done");
      apb(1'b1, phrs_pkg::IRQMASK_BYTE, 32'h02000000);
      check({31'h0, irq}, 32'h0, "irq idle");
      // A result that arrives while the clock enable is low is not taken
      clkEn <= 1'b0;
      tempDone <= 1'b1;
      @(posedge clock);
      tempDone <= 1'b0;
      clkEn <= 1'b1;
      @(posedge clock);
      rd(phrs_pkg::STAT0_BYTE, 32'h0, "frozen keeps");
      tempDone <= 1'b1;
      @(posedge clock);
      tempDone <= 1'b0;
      rd(phrs_pkg::STAT0_BYTE, 32'h02000000, "temp ready");
      check({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b1, phrs_pkg::STAT0_BYTE, 32'h0);
      rd(phrs_pkg::STAT0_BYTE, 32'h02000000, "write zero keeps");
      apb(1'b1, phrs_pkg::IRQMASK_BYTE, 32'h0);
      check({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, phrs_pkg::STAT0_BYTE, 32'h02000000);
      rd(phrs_pkg::STAT0_BYTE, 32'h0, "write one clears");
      $display("test temperature done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
